// [hdl/esic_pkg.sv]
// Purpose: Shared constants and types for the eight-source interrupt controller
// Assumes: Source numbering equals the fixed polling order, 0 polled first
// Notes:   Vector addresses are spaced evenly from the first one
package esic_pkg;

  // Source indices, in polling order
  localparam logic [2:0] SRC_EXT0   = 3'h0;
  localparam logic [2:0] SRC_TMR0   = 3'h1;
  localparam logic [2:0] SRC_EXT1   = 3'h2;
  localparam logic [2:0] SRC_TMR1   = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_CONV   = 3'h5;
  localparam logic [2:0] SRC_LVOLT  = 3'h6;
  localparam logic [2:0] SRC_PCA    = 3'h7;
  localparam int         NUM_SRC    = 8;
  localparam int         NUM_LVL    = 4;

  // Enable register layout and reset values
  localparam int         EN_GLOBAL_BIT = 7;
  localparam logic [7:0] EN_RST        = 8'h00;
  localparam logic [7:0] PRIO_RST      = 8'h00;

  // Vector table: first address and spacing between sources
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // In-service record
  localparam logic [3:0] IS_NONE = 4'h0;
  localparam logic [1:0] LVL_LOW = 2'h0;

  // Request flags held by the controller
  typedef struct packed {
    logic ext0;
    logic tmr0;
    logic ext1;
    logic tmr1;
    logic rx_done;
    logic tx_done;
    logic adc;
    logic lvolt;
    logic pca_ovf;
    logic pca_m0;
    logic pca_m1;
  } esic_flags_t;

  localparam esic_flags_t FLAGS_RST = '0;

  // Hardware events that set flags, one-cycle pulses
  typedef struct packed {
    logic tmr0;
    logic tmr1;
    logic rx_done;
    logic tx_done;
    logic adc;
    logic lvolt;
    logic pca_ovf;
    logic pca_m0;
    logic pca_m1;
  } esic_evt_t;

  // Counter-array enables
  typedef struct packed {
    logic ovf;
    logic m0;
    logic m1;
  } esic_pca_en_t;

  typedef enum logic [0:0] {
    ESIC_RUN,
    ESIC_VECTOR
  } esic_state_t;

endpackage

// [hdl/esic_ctrl.sv]
// Purpose: Eight-source, four-level interrupt controller for an 8-bit core
// Assumes: All inputs synchronous to clk_sys; core pulses instr_end at each
//          instruction boundary and ret_isr when it executes return_from_isr
// Notes:   Flags are held here; software writes them through the flag_wr ports
`timescale 1ns/1ps

// Operation
// [RULE1] Eight sources, each with four levels
// [RULE2] Global enable off blocks every acknowledge
// [RULE3] Source taken only with own and global enable
// [RULE4] Flags set regardless; disabled flags ignored
// [RULE5] At instruction end, force call to vector
// [RULE6] Return from service releases the active level
// [RULE7] Level is high bit then low bit
// [RULE8] Lower level never preempts running routine
// [RULE9] Higher level wins among simultaneous requests
// [RULE10] Equal level resolved by fixed polling order
// [RULE11] Fixed vector address per source
// [RULE12] External pins level or edge per select
// [RULE13] External flag cleared on vector only edge-mode
// [RULE14] Timer flags set on rollover, cleared on vector
// [RULE15] Serial request ORs rx/tx, software clears
// [RULE16] Converter flag request, software clears
// [RULE17] Low-voltage flag request, software clears
// [RULE18] Counter-array flags ORed, each individually enabled
// [RULE19] Software flag writes act like hardware events
// [RULE20] Enable register bit layout, resets zero
// [RULE21] Priority registers per-source bit layout
// [RULE22] In-service levels tracked, cleared at reset
module esic_ctrl
  import esic_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [7:0]   irq_enable_reg,
  input  wire logic [7:0]   priority_low_bits,
  input  wire logic [7:0]   priority_high_bits,
  input  wire esic_pca_en_t pca_irq_en,
  input  wire logic         ext0_edge_select,
  input  wire logic         ext1_edge_select,
  input  wire logic         ext_pin0_n,
  input  wire logic         ext_pin1_n,
  input  wire esic_evt_t    hw_evt,
  input  wire esic_flags_t  flag_wr,
  input  wire esic_flags_t  flag_wdata,
  input  wire logic         instr_end,
  input  wire logic         ret_isr,
  output logic              long_subroutine_call_req_r,
  output logic [15:0]       vector_r,
  output logic [2:0]        irq_src_r,
  output logic              irq_pending_r,
  output esic_flags_t       flags_r,
  output logic [3:0]        in_service_r
);

  // Level of one source from the two priority bytes
  function automatic logic [1:0] esic_level(input logic [7:0] hi, input logic [7:0] lo,
                                            input logic [2:0] idx);
    esic_level = {hi[idx], lo[idx]};
  endfunction

  // Common flag update: a set always beats a clear in the same cycle
  function automatic logic esic_flag(input logic cur, input logic set, input logic wr,
                                     input logic wd, input logic hwclr);
    esic_flag = set | (wr ? wd : (hwclr ? 1'b0 : cur));
  endfunction

  // Drop the highest in-service level
  function automatic logic [3:0] esic_release(input logic [3:0] is);
    logic [3:0] r;
    logic       done;
    r    = is;
    done = 1'b0;
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      if (!done && is[l]) begin
        r[l] = 1'b0;
        done = 1'b1;
      end
    end
    esic_release = r;
  endfunction

  esic_state_t state_r;
  esic_state_t state_nxt;
  logic        long_subroutine_call_nxt;
  logic [15:0] vector_nxt;
  logic [2:0]  src_nxt;
  logic [1:0]  call_lvl_r;
  logic [1:0]  call_lvl_nxt;
  logic [3:0]  in_service_nxt;
  esic_flags_t flags_nxt;
  logic        pin0_prev_r;
  logic        pin1_prev_r;
  logic [7:0]  req;
  logic [7:0]  req_en;
  logic        win_valid;
  logic [2:0]  win_src;
  logic [1:0]  win_lvl;
  logic        take;

  // Raw requests per source; counter-array bits gated one by one
  // [RULE15] [RULE16] [RULE17] [RULE18] request sources
  always_comb begin
    req[SRC_EXT0]   = flags_r.ext0;
    req[SRC_TMR0]   = flags_r.tmr0;
    req[SRC_EXT1]   = flags_r.ext1;
    req[SRC_TMR1]   = flags_r.tmr1;
    req[SRC_SERIAL] = flags_r.rx_done | flags_r.tx_done;
    req[SRC_CONV]   = flags_r.adc;
    req[SRC_LVOLT]  = flags_r.lvolt;
    req[SRC_PCA]    = (flags_r.pca_ovf & pca_irq_en.ovf) | (flags_r.pca_m0 & pca_irq_en.m0)
                    | (flags_r.pca_m1 & pca_irq_en.m1);
  end

  // Enable gating; bit 7 of the enable byte is global, not a source
  // [RULE2] [RULE3] [RULE20] enable gating
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == int'(SRC_PCA)) begin
        req_en[i] = irq_enable_reg[EN_GLOBAL_BIT] & req[i];
      end else begin
        req_en[i] = irq_enable_reg[EN_GLOBAL_BIT] & irq_enable_reg[i] & req[i];
      end
    end
  end

  // Arbitration: highest level first, then polling order. A level is
  // eligible only above every level now in service.
  // [RULE7] [RULE8] [RULE9] [RULE10] [RULE21] level and poll order
  always_comb begin
    win_valid = 1'b0;
    win_src   = SRC_EXT0;
    win_lvl   = LVL_LOW;
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (!win_valid && req_en[i] && ((in_service_r >> l) == IS_NONE)
            && (esic_level(priority_high_bits, priority_low_bits, 3'(i)) == 2'(l))) begin
          win_valid = 1'b1;
          win_src   = 3'(i);
          win_lvl   = 2'(l);
        end
      end
    end
  end

  // Sequencer: one call per boundary, then a settling cycle so the
  // just-cleared flag cannot be taken twice
  // [RULE5] [RULE11] [RULE6] [RULE22] call and in-service tracking
  always_comb begin
    state_nxt      = state_r;
    long_subroutine_call_nxt      = 1'b0;
    vector_nxt     = vector_r;
    src_nxt        = irq_src_r;
    call_lvl_nxt   = call_lvl_r;
    in_service_nxt = in_service_r;
    take           = 1'b0;
    if (ret_isr) begin
      in_service_nxt = esic_release(in_service_r);
    end
    case (state_r)
      ESIC_RUN: begin
        if (instr_end && win_valid) begin
          take          = 1'b1;
          long_subroutine_call_nxt     = 1'b1;
          vector_nxt    = VEC_BASE + (VEC_STEP * 16'(win_src));
          src_nxt       = win_src;
          call_lvl_nxt  = win_lvl;
          in_service_nxt[win_lvl] = 1'b1;
          state_nxt     = ESIC_VECTOR;
        end
      end
      ESIC_VECTOR: begin
        state_nxt = ESIC_RUN;
      end
      default: begin
        state_nxt = ESIC_RUN;
      end
    endcase
  end

  // Flag update. Level-mode external flags mirror the pin, so software
  // writes to them are overridden by the source, as the pin rules.
  // [RULE4] [RULE12] [RULE13] [RULE14] [RULE19] flag set and clear
  always_comb begin
    flags_nxt = flags_r;
    if (ext0_edge_select) begin
      flags_nxt.ext0 = esic_flag(flags_r.ext0, pin0_prev_r & ~ext_pin0_n, flag_wr.ext0,
                                 flag_wdata.ext0, take && (win_src == SRC_EXT0));
    end else begin
      flags_nxt.ext0 = ~ext_pin0_n;
    end
    if (ext1_edge_select) begin
      flags_nxt.ext1 = esic_flag(flags_r.ext1, pin1_prev_r & ~ext_pin1_n, flag_wr.ext1,
                                 flag_wdata.ext1, take && (win_src == SRC_EXT1));
    end else begin
      flags_nxt.ext1 = ~ext_pin1_n;
    end
    // Timer flags are the only non-external ones cleared on vectoring
    flags_nxt.tmr0    = esic_flag(flags_r.tmr0, hw_evt.tmr0, flag_wr.tmr0, flag_wdata.tmr0,
                                  take && (win_src == SRC_TMR0));
    flags_nxt.tmr1    = esic_flag(flags_r.tmr1, hw_evt.tmr1, flag_wr.tmr1, flag_wdata.tmr1,
                                  take && (win_src == SRC_TMR1));
    // Software-cleared flags: the service routine must find out who asked
    flags_nxt.rx_done = esic_flag(flags_r.rx_done, hw_evt.rx_done, flag_wr.rx_done,
                                  flag_wdata.rx_done, 1'b0);
    flags_nxt.tx_done = esic_flag(flags_r.tx_done, hw_evt.tx_done, flag_wr.tx_done,
                                  flag_wdata.tx_done, 1'b0);
    flags_nxt.adc     = esic_flag(flags_r.adc, hw_evt.adc, flag_wr.adc, flag_wdata.adc, 1'b0);
    flags_nxt.lvolt   = esic_flag(flags_r.lvolt, hw_evt.lvolt, flag_wr.lvolt,
                                  flag_wdata.lvolt, 1'b0);
    flags_nxt.pca_ovf = esic_flag(flags_r.pca_ovf, hw_evt.pca_ovf, flag_wr.pca_ovf,
                                  flag_wdata.pca_ovf, 1'b0);
    flags_nxt.pca_m0  = esic_flag(flags_r.pca_m0, hw_evt.pca_m0, flag_wr.pca_m0,
                                  flag_wdata.pca_m0, 1'b0);
    flags_nxt.pca_m1  = esic_flag(flags_r.pca_m1, hw_evt.pca_m1, flag_wr.pca_m1,
                                  flag_wdata.pca_m1, 1'b0);
  end

  // Register stage; pin history resets idle-high so no false edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= ESIC_RUN;
      long_subroutine_call_req_r   <= 1'b0;
      vector_r      <= VEC_BASE;
      irq_src_r     <= SRC_EXT0;
      call_lvl_r    <= LVL_LOW;
      irq_pending_r <= 1'b0;
      in_service_r  <= IS_NONE;
      flags_r       <= FLAGS_RST;
      pin0_prev_r   <= 1'b1;
      pin1_prev_r   <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      long_subroutine_call_req_r   <= long_subroutine_call_nxt;
      vector_r      <= vector_nxt;
      irq_src_r     <= src_nxt;
      call_lvl_r    <= call_lvl_nxt;
      irq_pending_r <= win_valid;
      in_service_r  <= in_service_nxt;
      flags_r       <= flags_nxt;
      pin0_prev_r   <= ext_pin0_n;
      pin1_prev_r   <= ext_pin1_n;
    end
  end

  // Checks on the call sequence and the flag handling
  sequence s_call;
    long_subroutine_call_req_r;
  endsequence

  sequence s_settle;
    !long_subroutine_call_req_r;
  endsequence

  a_global_gate: assert property ( // [RULE2]
    @(posedge clk_sys) disable iff (!rst_n)
    !irq_enable_reg[EN_GLOBAL_BIT] |=> !long_subroutine_call_req_r)
    else $error("call issued with global enable off");

  a_call_boundary: assert property ( // [RULE5]
    @(posedge clk_sys) disable iff (!rst_n)
    s_call |-> $past(instr_end) ##1 s_settle)
    else $error("call not at boundary or not followed by settle cycle");

  a_vector_map: assert property ( // [RULE11]
    @(posedge clk_sys) disable iff (!rst_n)
    s_call |-> vector_r == VEC_BASE + (VEC_STEP * 16'(irq_src_r)))
    else $error("vector does not match source");

  a_no_preempt: assert property ( // [RULE8]
    @(posedge clk_sys) disable iff (!rst_n)
    s_call |-> (($past(in_service_r) >> call_lvl_r) == IS_NONE) && in_service_r[call_lvl_r])
    else $error("call at level not above active routine");

  // The enable byte is sampled at the call edge, indexed by the new source
  a_enabled_only: assert property ( // [RULE3]
    @(posedge clk_sys) disable iff (!rst_n)
    (s_call and (irq_src_r != SRC_PCA))
    |-> (($past(irq_enable_reg) >> irq_src_r) & 8'h01) != 8'h00)
    else $error("call for disabled source");

  a_timer_clear: assert property ( // [RULE14]
    @(posedge clk_sys) disable iff (!rst_n)
    (s_call and (irq_src_r == SRC_TMR0 && !$past(hw_evt.tmr0) && !$past(flag_wr.tmr0)))
    |-> !flags_r.tmr0)
    else $error("timer 0 flag not cleared on vector");

  a_serial_keep: assert property ( // [RULE15]
    @(posedge clk_sys) disable iff (!rst_n)
    (s_call and (irq_src_r == SRC_SERIAL && !$past(flag_wr.rx_done)
                 && !$past(flag_wr.tx_done)))
    |-> flags_r.rx_done | flags_r.tx_done)
    else $error("serial flags cleared by vectoring");

  a_edge_clear: assert property ( // [RULE13]
    @(posedge clk_sys) disable iff (!rst_n)
    (s_call and (irq_src_r == SRC_EXT0 && $past(ext0_edge_select) && !$past(flag_wr.ext0)
                 && !$past(pin0_prev_r & ~ext_pin0_n)))
    |-> !flags_r.ext0)
    else $error("edge external flag not cleared on vector");

  // Level mode: the pin, not the controller, owns the flag
  a_level_follow: assert property ( // [RULE13]
    @(posedge clk_sys) disable iff (!rst_n)
    !ext0_edge_select |=> flags_r.ext0 == !$past(ext_pin0_n))
    else $error("level external flag does not follow pin");

  // A counter-array call needs at least one flag with its own enable set
  a_pca_gate: assert property ( // [RULE18]
    @(posedge clk_sys) disable iff (!rst_n)
    (s_call and (irq_src_r == SRC_PCA))
    |-> $past((flags_r.pca_ovf & pca_irq_en.ovf) | (flags_r.pca_m0 & pca_irq_en.m0)
              | (flags_r.pca_m1 & pca_irq_en.m1)))
    else $error("counter-array call with no enabled flag");

  a_return_from_isr_release: assert property ( // [RULE6]
    @(posedge clk_sys) disable iff (!rst_n)
    ret_isr && (in_service_r != IS_NONE) && !(state_r == ESIC_RUN && instr_end && win_valid)
    |=> $countones(in_service_r) == $countones($past(in_service_r)) - 1)
    else $error("return did not release a level");

endmodule

// [verif/esic_core_model.sv]
// Purpose: Core sequencer model facing the interrupt controller
// Assumes: One instruction boundary per cycle while run is high
// Notes:   Returns are issued only on bench command, one per request
`timescale 1ns/1ps
module esic_core_model
  import esic_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  run,
  input  wire logic  do_ret,
  input  wire logic  long_subroutine_call_req_r,
  output logic       instr_end,
  output logic       ret_isr,
  output logic [7:0] n_calls
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_end <= 1'b0;
      ret_isr   <= 1'b0;
      n_calls   <= 8'h00;
    end else begin
      instr_end <= run;
      ret_isr   <= do_ret;
      n_calls   <= n_calls + {7'h00, long_subroutine_call_req_r};
    end
  end
endmodule

// [verif/eight_source_interrupt_controller_bench.sv]
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model offers a boundary every cycle while run is high
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module eight_source_interrupt_controller_bench;
  import esic_pkg::*;
  logic         clk_sys = 1'b0, rst_n = 1'b0, run = 1'b0, do_ret = 1'b0;
  logic         e0s = 1'b1, e1s = 1'b1, pin0_n = 1'b1, pin1_n = 1'b1;
  logic         instr_end, ret_isr, long_subroutine_call_req_r, irq_pending_r;
  logic [7:0]   en_byte = 8'hff, prio_lo = 8'h00, prio_hi = 8'h00, n_calls, c0;
  logic [15:0]  vector_r;
  logic [2:0]   irq_src_r;
  logic [3:0]   in_service_r;
  esic_pca_en_t arr_en = 3'h7;
  esic_evt_t    evt = '0;
  esic_flags_t  fwr = '0, fwd = '0, flags_r;
  int           fail_count = 0, n_compared = 0;
  // Flag bit of each source, in polling order
  localparam int FPOS[8] = '{10, 9, 8, 7, 6, 4, 3, 2};

  esic_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .irq_enable_reg(en_byte),
    .priority_low_bits(prio_lo), .priority_high_bits(prio_hi), .pca_irq_en(arr_en),
    .ext0_edge_select(e0s), .ext1_edge_select(e1s), .ext_pin0_n(pin0_n),
    .ext_pin1_n(pin1_n), .hw_evt(evt), .flag_wr(fwr), .flag_wdata(fwd),
    .instr_end(instr_end), .ret_isr(ret_isr), .long_subroutine_call_req_r(long_subroutine_call_req_r),
    .vector_r(vector_r), .irq_src_r(irq_src_r), .irq_pending_r(irq_pending_r),
    .flags_r(flags_r), .in_service_r(in_service_r));
  esic_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .do_ret(do_ret),
    .long_subroutine_call_req_r(long_subroutine_call_req_r), .instr_end(instr_end), .ret_isr(ret_isr), .n_calls(n_calls));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Software flag write, one-cycle strobe
  task automatic swr(input esic_flags_t m, input esic_flags_t v);
    fwr = m;
    fwd = v;
    tick(1);
    fwr = '0;
  endtask
  task automatic ret_one;
    do_ret = 1'b1;
    tick(1);
    do_ret = 1'b0;
  endtask
  // Bounded wait for a call, then vector, source and pending flag compared
  task automatic wait_call(input logic [2:0] s);
    for (int i = 0; i < 20 && long_subroutine_call_req_r !== 1'b1; i++) tick(1);
    chk("call", 16'h1, {15'h0, long_subroutine_call_req_r});
    chk("vector", 16'h0003 + {10'h0, s, 3'h0}, vector_r);
    chk("source", {13'h0, s}, {13'h0, irq_src_r});
    chk("pending", 16'h1, {15'h0, irq_pending_r});
  endtask
  task automatic t_gate;
    en_byte = 8'h7f;
    evt.tmr0 = 1'b1;
    tick(1);
    evt = '0;
    run = 1'b1;
    c0 = n_calls;
    tick(8);
    chk("global off", {8'h0, c0}, {8'h0, n_calls});
    chk("pend global off", 16'h0, {15'h0, irq_pending_r});
    chk("tmr0 held", 16'h1, {15'h0, flags_r.tmr0});
    en_byte = 8'h8d;
    tick(8);
    chk("own off", {8'h0, c0}, {8'h0, n_calls});
    chk("pend own off", 16'h0, {15'h0, irq_pending_r});
    en_byte = 8'hff;
    wait_call(3'h1);
    chk("tmr0 clear", 16'h0, {15'h0, flags_r.tmr0});
    chk("lvl0 on", 16'h1, {12'h0, in_service_r});
    ret_one;
    tick(2);
    chk("released", 16'h0, {12'h0, in_service_r});
  endtask
  // Counter-array match event held back by its own enable, then taken
  task automatic t_pca;
    arr_en = 3'h5;
    evt.pca_m0 = 1'b1;
    tick(1);
    evt = '0;
    c0 = n_calls;
    tick(6);
    chk("pca gated", {8'h0, c0}, {8'h0, n_calls});
    chk("pca flag", 16'h1, {15'h0, flags_r.pca_m0});
    arr_en = 3'h7;
    wait_call(3'h7);
    chk("pca kept", 16'h1, {15'h0, flags_r.pca_m0});
    swr(esic_flags_t'(11'h002), '0);
    ret_one;
    tick(2);
    chk("pca idle", 16'h0, {12'h0, in_service_r});
  endtask
  task automatic t_vectors;
    esic_flags_t f;
    for (int s = 0; s < 8; s++) begin
      f = esic_flags_t'(11'h1 << FPOS[s]);
      swr(f, f);
      wait_call(s[2:0]);
      chk("flag kept", (s < 4) ? 16'h0 : 16'h1, {15'h0, |(flags_r & f)});
      swr(f, '0);
      ret_one;
      tick(2);
      chk("idle", 16'h0, {12'h0, in_service_r});
    end
  endtask
  task automatic t_poll;
    run = 1'b0;
    swr(esic_flags_t'(11'h1c0), esic_flags_t'(11'h1c0));
    run = 1'b1;
    wait_call(3'h2);
    ret_one;
    wait_call(3'h3);
    ret_one;
    wait_call(3'h4);
    swr(esic_flags_t'(11'h040), '0);
    ret_one;
  endtask
  task automatic t_ext;
    e0s = 1'b0;
    pin0_n = 1'b0;
    wait_call(3'h0);
    tick(1);
    chk("lvl flag", 16'h1, {15'h0, flags_r.ext0});
    pin0_n = 1'b1;
    tick(2);
    chk("pin follow", 16'h0, {15'h0, flags_r.ext0});
    ret_one;
    pin1_n = 1'b0;
    wait_call(3'h2);
    chk("edge clear", 16'h0, {15'h0, flags_r.ext1});
    pin1_n = 1'b1;
    ret_one;
  endtask
  task automatic t_prio;
    run = 1'b0;
    prio_hi = 8'h40;
    prio_lo = 8'h40;
    evt.tmr0 = 1'b1;
    evt.lvolt = 1'b1;
    tick(1);
    evt = '0;
    run = 1'b1;
    wait_call(3'h6);
    chk("lvl3 on", 16'h8, {12'h0, in_service_r});
    swr(esic_flags_t'(11'h008), '0);
    c0 = n_calls;
    tick(6);
    chk("no preempt", {8'h0, c0}, {8'h0, n_calls});
    chk("pend blocked", 16'h0, {15'h0, irq_pending_r});
    ret_one;
    wait_call(3'h1);
    chk("lvl0 on", 16'h1, {12'h0, in_service_r});
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Free-running 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog at 25000 cycles, far beyond the hundred-odd cycles the tests need
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    tick(4);
    rst_n = 1'b1;
    chk("rst flags", 16'h0, {5'h0, flags_r});
    chk("rst vector", 16'h0003, vector_r);
    chk("rst lvls", 16'h0, {12'h0, in_service_r});
    t_gate();
    t_pca();
    t_vectors();
    t_poll();
    t_ext();
    t_prio();
    tally_and_finish();
  end
endmodule
